// ---- design/flash_seq_pkg.sv ----
// Constants, register map and state type of the flash self-program sequencer.
// Assumes a single 50 MHz system clock and a classic Wishbone register bus.
//
// What this block does
// - Core is held stalled while any erase or program operation runs.
// - A row write lasts 11064 cycles of the 7.37 MHz internal fast oscillator.
// - Setting bit 15 of the control register launches; hardware clears it when done.
// - Unlock register is write-only; 0x55 then 0xAA on consecutive writes.
// - No erase or program proceeds without the unlock sequence.
// - Page erase: operation code 0010, erase bit 6 set, write enable bit 14 set.
// - A dummy low table write inside a page latches that page as erase target.
// - Erase clears a whole page of eight rows, 512 instructions.
// - Row program: operation code 0001, erase bit clear, write enable set.
// - Buffer words come from one 64-instruction aligned block, in sequential order.
// - Target address is table page bits 7:0 joined with the effective address.
package flash_seq_pkg;

	// Clock and oscillator rates
	localparam int unsigned CLK_FREQ_KHZ          = 50000;
	localparam int unsigned FRC_FREQ_KHZ          = 7370;
	localparam int unsigned ROW_WRITE_FRC_CYCLES  = 11064;
	localparam int unsigned PAGE_ERASE_FRC_CYCLES = 11064;

	// Register byte offsets
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_KEY     = 8'h04;
	localparam logic [7:0] ADDR_PAGE    = 8'h08;
	localparam logic [7:0] ADDR_EA      = 8'h0c;
	localparam logic [7:0] ADDR_TBL_LOW = 8'h10;
	localparam logic [7:0] ADDR_TBL_HIGH = 8'h14;
	localparam logic [7:0] ADDR_STATUS  = 8'h18;

	// Control register fields
	localparam int unsigned CTRL_START_BIT = 15;
	localparam int unsigned CTRL_WRITE_ENABLE_BIT_BIT  = 14;
	localparam int unsigned CTRL_ERASE_BIT = 6;
	localparam int unsigned CTRL_OP_MSB    = 3;
	localparam int unsigned CTRL_OP_LSB    = 0;
	localparam logic [15:0] CTRL_WR_MASK   = 16'hc04f;
	localparam logic [15:0] CTRL_RESET     = 16'h0000;
	localparam logic [3:0]  OP_PAGE_ERASE  = 4'h2;
	localparam logic [3:0]  OP_ROW_PROG    = 4'h1;

	// Unlock key values
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;

	// Address geometry: two program addresses per instruction
	localparam int unsigned ROW_WORDS     = 64;
	localparam int unsigned ROW_ADDR_LSB  = 7;
	localparam int unsigned PAGE_ADDR_LSB = 10;
	localparam int unsigned IDX_LSB       = 1;

	// Status register fields
	localparam int unsigned STAT_BUSY_BIT    = 0;
	localparam int unsigned STAT_UNLOCK_BIT  = 1;
	localparam int unsigned STAT_REFUSED_BIT = 2;
	localparam int unsigned STAT_PAGE_LSB    = 16;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_ERASE   = 3'b001,
		ST_PROGRAM = 3'b010,
		ST_WAIT    = 3'b011,
		ST_FINISH  = 3'b100
	} seq_state_type;

endpackage : flash_seq_pkg

// ---- design/osc_tick_gen.sv ----
// Fractional divider giving one-cycle pulses at the internal fast oscillator rate.
// Assumes clk_i runs at CLK_FREQ_KHZ and FRC_KHZ is below it.
`timescale 1ns/1ps
module osc_tick_gen
	import flash_seq_pkg::*;
#(
	parameter int unsigned CLK_KHZ = CLK_FREQ_KHZ,
	parameter int unsigned FRC_KHZ = FRC_FREQ_KHZ
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Oscillator cycle pulse
	output logic      tick_o
);
	logic [16:0] acc_ff;
	logic [16:0] nxt_acc;
	logic        tick_ff;
	logic        nxt_tick;
	logic [16:0] sum;

	always_comb begin
		sum = acc_ff + 17'(FRC_KHZ);
		if (sum >= 17'(CLK_KHZ)) begin
			nxt_acc  = sum - 17'(CLK_KHZ);
			nxt_tick = 1'b1;
		end else begin
			nxt_acc  = sum;
			nxt_tick = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_ff  <= 17'h00000;
			tick_ff <= 1'b0;
		end else begin
			acc_ff  <= nxt_acc;
			tick_ff <= nxt_tick;
		end
	end

	assign tick_o = tick_ff;
endmodule : osc_tick_gen

// ---- design/unlock_key_watch.sv ----
// Tracks the two-write unlock sequence on the key register.
// Assumes one-cycle write strobes from the register slave.
`timescale 1ns/1ps
module unlock_key_watch
	import flash_seq_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Register writes
	input  wire logic       key_wr_i,
	input  wire logic       other_wr_i,
	input  wire logic [7:0] key_data_i,
	// Unlock state
	output logic            unlocked_o
);
	logic armed_ff;
	logic nxt_armed;
	logic unlocked_ff;
	logic nxt_unlocked;

	always_comb begin
		nxt_armed    = armed_ff;
		nxt_unlocked = unlocked_ff;
		if (key_wr_i) begin
			nxt_unlocked = armed_ff && (key_data_i == KEY_SECOND);
			nxt_armed    = (key_data_i == KEY_FIRST);
		end else if (other_wr_i) begin
			nxt_armed    = 1'b0;
			nxt_unlocked = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			armed_ff    <= 1'b0;
			unlocked_ff <= 1'b0;
		end else begin
			armed_ff    <= nxt_armed;
			unlocked_ff <= nxt_unlocked;
		end
	end

	assign unlocked_o = unlocked_ff;
endmodule : unlock_key_watch

// ---- design/flash_self_program_sequencer.sv ----
// Flash self-program sequencer: register slave, holding buffer, erase and row program.
// Assumes a classic Wishbone master and a flash array taking one word per write strobe.
`timescale 1ns/1ps
module flash_self_program_sequencer
	import flash_seq_pkg::*;
#(
	parameter int unsigned ROW_FRC_CYCLES   = ROW_WRITE_FRC_CYCLES,
	parameter int unsigned ERASE_FRC_CYCLES = PAGE_ERASE_FRC_CYCLES,
	parameter int unsigned CNT_W            = 16
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	// Core stall
	output logic             cpu_stall_o,
	// Flash array
	output logic             flash_erase_o,
	output logic             flash_write_o,
	output logic [23:0]      flash_addr_o,
	output logic [23:0]      flash_wdata_o
);
	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
			input logic [1:0] sel);
		merge16 = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
	endfunction : merge16

	logic [23:0]   row_buf [ROW_WORDS];

	seq_state_type state_ff;
	seq_state_type nxt_state;
	logic [15:0]   ctrl_ff;
	logic [15:0]   nxt_ctrl;
	logic [7:0]    page_ff;
	logic [7:0]    nxt_page;
	logic [15:0]   ea_ff;
	logic [15:0]   nxt_ea;
	logic [13:0]   erase_pg_ff;
	logic [13:0]   nxt_erase_pg;
	logic [16:0]   row_ff;
	logic [16:0]   nxt_row;
	logic          refused_ff;
	logic          nxt_refused;
	logic [5:0]    idx_ff;
	logic [5:0]    nxt_idx;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic [CNT_W-1:0] target_ff;
	logic [CNT_W-1:0] nxt_target;
	logic          ack_ff;
	logic          nxt_ack;
	logic [31:0]   dat_ff;
	logic [31:0]   nxt_dat;
	logic          erase_ff;
	logic          nxt_erase;
	logic          write_ff;
	logic          nxt_write;
	logic [23:0]   faddr_ff;
	logic [23:0]   nxt_faddr;
	logic [23:0]   fdata_ff;
	logic [23:0]   nxt_fdata;

	logic          req;
	logic          wr_req;
	logic          key_wr;
	logic          other_wr;
	logic          unlocked;
	logic          tick;
	logic [23:0]   tbl_addr;
	logic [5:0]    tbl_idx;
	logic          buf_wr_low;
	logic          buf_wr_high;
	logic [15:0]   ctrl_wdata;
	logic          start_req;
	logic          is_erase_op;
	logic          is_prog_op;
	logic          start_ok;

	osc_tick_gen u_tick (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.tick_o (tick)
	);

	assign req      = cyc_i && stb_i && !ack_ff;
	assign wr_req   = req && we_i && (state_ff == ST_IDLE);
	assign key_wr   = wr_req && (adr_i == ADDR_KEY) && sel_i[0];
	assign other_wr = wr_req && !key_wr;

	unlock_key_watch u_key (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.key_wr_i   (key_wr),
		.other_wr_i (other_wr),
		.key_data_i (dat_i[7:0]),
		.unlocked_o (unlocked)
	);

	// Table address from page and effective address
	assign tbl_addr    = {page_ff, ea_ff};
	assign tbl_idx     = tbl_addr[IDX_LSB +: 6];
	assign buf_wr_low  = wr_req && (adr_i == ADDR_TBL_LOW);
	assign buf_wr_high = wr_req && (adr_i == ADDR_TBL_HIGH) && sel_i[0];

	// Start decode
	assign ctrl_wdata  = merge16(ctrl_ff, dat_i[15:0], sel_i[1:0]) & CTRL_WR_MASK;
	assign start_req   = wr_req && (adr_i == ADDR_CONTROL) && ctrl_wdata[CTRL_START_BIT];
	assign is_erase_op = (ctrl_wdata[CTRL_OP_MSB:CTRL_OP_LSB] == OP_PAGE_ERASE)
		&& ctrl_wdata[CTRL_ERASE_BIT];
	assign is_prog_op  = (ctrl_wdata[CTRL_OP_MSB:CTRL_OP_LSB] == OP_ROW_PROG)
		&& !ctrl_wdata[CTRL_ERASE_BIT];
	assign start_ok    = start_req && unlocked && ctrl_wdata[CTRL_WRITE_ENABLE_BIT_BIT]
		&& (is_erase_op || is_prog_op);

	// Holding buffer
	always_ff @(posedge clk_i) begin
		if (buf_wr_low) begin
			row_buf[tbl_idx][15:0] <= merge16(row_buf[tbl_idx][15:0], dat_i[15:0], sel_i[1:0]);
		end
		if (buf_wr_high) begin
			row_buf[tbl_idx][23:16] <= dat_i[7:0];
		end
	end

	// Register slave
	always_comb begin
		nxt_ack      = req;
		nxt_dat      = dat_ff;
		nxt_ctrl     = ctrl_ff;
		nxt_page     = page_ff;
		nxt_ea       = ea_ff;
		nxt_erase_pg = erase_pg_ff;
		nxt_row      = row_ff;
		nxt_refused  = refused_ff;
		if (req && !we_i) begin
			case (adr_i)
				ADDR_CONTROL: begin
					nxt_dat = {16'h0000, ctrl_ff};
				end
				ADDR_PAGE: begin
					nxt_dat = {24'h000000, page_ff};
				end
				ADDR_EA: begin
					nxt_dat = {16'h0000, ea_ff};
				end
				ADDR_STATUS: begin
					nxt_dat = {2'b00, erase_pg_ff, 13'h0000, refused_ff, unlocked, state_ff != ST_IDLE};
				end
				default: begin
					nxt_dat = 32'h00000000;
				end
			endcase
		end
		if (wr_req) begin
			case (adr_i)
				ADDR_CONTROL: begin
					nxt_ctrl = ctrl_wdata;
					if (start_req && !start_ok) begin
						nxt_ctrl[CTRL_START_BIT] = 1'b0;
					end
					if (start_req) begin
						nxt_refused = !start_ok;
					end
				end
				ADDR_PAGE: begin
					nxt_page = sel_i[0] ? dat_i[7:0] : page_ff;
				end
				ADDR_EA: begin
					nxt_ea = merge16(ea_ff, dat_i[15:0], sel_i[1:0]);
				end
				ADDR_TBL_LOW: begin
					nxt_erase_pg = tbl_addr[23:PAGE_ADDR_LSB];
					nxt_row      = tbl_addr[23:ROW_ADDR_LSB];
				end
				ADDR_TBL_HIGH: begin
					nxt_row = tbl_addr[23:ROW_ADDR_LSB];
				end
				default: begin
					nxt_dat = dat_ff;
				end
			endcase
		end
		if (state_ff == ST_FINISH) begin
			nxt_ctrl[CTRL_START_BIT] = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff      <= 1'b0;
			dat_ff      <= 32'h00000000;
			ctrl_ff     <= CTRL_RESET;
			page_ff     <= 8'h00;
			ea_ff       <= 16'h0000;
			erase_pg_ff <= 14'h0000;
			row_ff      <= 17'h00000;
			refused_ff  <= 1'b0;
		end else begin
			ack_ff      <= nxt_ack;
			dat_ff      <= nxt_dat;
			ctrl_ff     <= nxt_ctrl;
			page_ff     <= nxt_page;
			ea_ff       <= nxt_ea;
			erase_pg_ff <= nxt_erase_pg;
			row_ff      <= nxt_row;
			refused_ff  <= nxt_refused;
		end
	end

	// Operation sequencer
	always_comb begin
		nxt_state  = state_ff;
		nxt_idx    = idx_ff;
		nxt_cnt    = cnt_ff;
		nxt_target = target_ff;
		nxt_erase  = 1'b0;
		nxt_write  = 1'b0;
		nxt_faddr  = faddr_ff;
		nxt_fdata  = fdata_ff;
		case (state_ff)
			ST_IDLE: begin
				if (start_ok) begin
					nxt_idx = 6'h00;
					nxt_cnt = '0;
					if (is_erase_op) begin
						nxt_state  = ST_ERASE;
						nxt_target = CNT_W'(ERASE_FRC_CYCLES);
					end else begin
						nxt_state  = ST_PROGRAM;
						nxt_target = CNT_W'(ROW_FRC_CYCLES);
					end
				end
			end
			ST_ERASE: begin
				nxt_erase = 1'b1;
				nxt_faddr = {erase_pg_ff, 10'h000};
				nxt_state = ST_WAIT;
			end
			ST_PROGRAM: begin
				nxt_write = 1'b1;
				nxt_faddr = {row_ff, idx_ff, 1'b0};
				nxt_fdata = row_buf[idx_ff];
				nxt_idx   = idx_ff + 6'h01;
				if (idx_ff == 6'(ROW_WORDS - 1)) begin
					nxt_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (tick) begin
					nxt_cnt = cnt_ff + 1'b1;
					if (cnt_ff == target_ff - 1'b1) begin
						nxt_state = ST_FINISH;
					end
				end
			end
			ST_FINISH: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff  <= ST_IDLE;
			idx_ff    <= 6'h00;
			cnt_ff    <= '0;
			target_ff <= '0;
			erase_ff  <= 1'b0;
			write_ff  <= 1'b0;
			faddr_ff  <= 24'h000000;
			fdata_ff  <= 24'h000000;
		end else begin
			state_ff  <= nxt_state;
			idx_ff    <= nxt_idx;
			cnt_ff    <= nxt_cnt;
			target_ff <= nxt_target;
			erase_ff  <= nxt_erase;
			write_ff  <= nxt_write;
			faddr_ff  <= nxt_faddr;
			fdata_ff  <= nxt_fdata;
		end
	end

	assign cpu_stall_o   = (state_ff != ST_IDLE);
	assign ack_o         = ack_ff;
	assign dat_o         = dat_ff;
	assign flash_erase_o = erase_ff;
	assign flash_write_o = write_ff;
	assign flash_addr_o  = faddr_ff;
	assign flash_wdata_o = fdata_ff;
endmodule : flash_self_program_sequencer

// ---- sim/flash_seq_checker.sv ----
// Port assertions for the flash self-program sequencer.
// Assumes a bind to the top module and a shortened oscillator count.
`timescale 1ns/1ps
module flash_seq_checker
	import flash_seq_pkg::*;
#(
	parameter int unsigned ROW_FRC_CYCLES = ROW_WRITE_FRC_CYCLES
) (
	// Clock, reset and bus
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	// Stall and flash strobes
	input wire logic        cpu_stall_o,
	input wire logic        flash_erase_o,
	input wire logic        flash_write_o,
	input wire logic [23:0] flash_addr_o
);
	logic [31:0] stall_cnt_ff;
	logic [31:0] nxt_stall_cnt;
	logic        key_rd_ff;
	logic        nxt_key_rd;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	always_comb begin
		nxt_stall_cnt = cpu_stall_o ? stall_cnt_ff + 32'h1 : 32'h0;
		nxt_key_rd    = cyc_i && stb_i && !ack_o && !we_i && adr_i == ADDR_KEY;
	end
	always_ff @(posedge clk_i) begin
		stall_cnt_ff <= rst_i ? 32'h0 : nxt_stall_cnt;
		key_rd_ff    <= rst_i ? 1'b0 : nxt_key_rd;
	end
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_burst;
		flash_write_o [*8];
	endsequence
	a_ack_after_req: assert property (s_req |=> ack_o) else $error("ack missing");
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
	a_idle_no_ack: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("stray ack");
	a_key_reads_zero: assert property (ack_o && key_rd_ff |-> dat_o == 32'h0) else $error("key readable");
	a_strobe_stalled: assert property (flash_write_o || flash_erase_o |-> cpu_stall_o) else $error("no stall");
	a_erase_page_base: assert property (flash_erase_o |-> flash_addr_o[9:0] == 10'h000) else $error("page");
	a_row_burst: assert property ($rose(flash_write_o) |-> s_burst) else $error("burst broken");
	a_addr_step: assert property (flash_write_o && $past(flash_write_o)
		|-> flash_addr_o == $past(flash_addr_o) + 24'h2) else $error("address step");
	a_stall_min: assert property ($fell(cpu_stall_o) |-> stall_cnt_ff >= ROW_FRC_CYCLES * 6) else $error("short");
	a_stall_max: assert property (stall_cnt_ff <= ROW_FRC_CYCLES * 7 + 80) else $error("stall too long");
endmodule : flash_seq_checker

// ---- sim/flash_array_model.sv ----
// Behavioural flash array at the far side of the sequencer.
// Assumes one word per write strobe and one page per erase strobe.
`timescale 1ns/1ps
module flash_array_model (
	// Clock and flash strobes
	input wire logic        clk_i,
	input wire logic        erase_i,
	input wire logic        write_i,
	input wire logic [23:0] addr_i,
	input wire logic [23:0] wdata_i
);
	logic [23:0] row_mem [64];
	logic [23:0] erase_addr = 24'h0;
	logic [23:0] first_addr = 24'h0;
	int          erase_cnt  = 0;
	int          write_cnt  = 0;
	always @(posedge clk_i) begin
		if (erase_i) begin
			erase_cnt  <= erase_cnt + 1;
			erase_addr <= addr_i;
		end
		if (write_i) begin
			if (write_cnt % 64 == 0) first_addr <= addr_i;
			row_mem[addr_i[6:1]] <= wdata_i;
			write_cnt <= write_cnt + 1;
		end
	end
endmodule : flash_array_model

// ---- sim/tb.sv ----
// Self-checking bench: refused starts, page erase and row program.
// Assumes the sequencer, its checker and the flash array model.
`timescale 1ns/1ps
module tb;
	import flash_seq_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i  = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'hf;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o, rd;
	logic        ack_o, cpu_stall_o, flash_erase_o, flash_write_o;
	logic [23:0] flash_addr_o, flash_wdata_o;
	int          errors = 0;
	int          total_checks = 0;
	localparam int TEST_TICKS = 8;
	int          stall_run  = 0;
	int          stall_last = 0;
	always #10 clk_i = ~clk_i;
	// Length of the last stall, in clock cycles
	always @(posedge clk_i) begin
		if (cpu_stall_o === 1'b1) begin
			stall_run <= stall_run + 1;
		end else if (stall_run != 0) begin
			stall_last <= stall_run;
			stall_run  <= 0;
		end
	end
	flash_self_program_sequencer #(.ROW_FRC_CYCLES(TEST_TICKS), .ERASE_FRC_CYCLES(TEST_TICKS), .CNT_W(16)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cpu_stall_o(cpu_stall_o),
		.flash_erase_o(flash_erase_o), .flash_write_o(flash_write_o), .flash_addr_o(flash_addr_o),
		.flash_wdata_o(flash_wdata_o));
	flash_array_model u_flash (.clk_i(clk_i), .erase_i(flash_erase_o), .write_i(flash_write_o),
		.addr_i(flash_addr_o), .wdata_i(flash_wdata_o));
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		chk("ack", 32'h1, {31'h0, ack_o});
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb
	task automatic unlock();
		wb(1'b1, ADDR_KEY, 32'h55);
		wb(1'b1, ADDR_KEY, 32'haa);
	endtask : unlock
	task automatic wait_idle(input logic [31:0] ctl, input int extra);
		int n;
		int lo;
		int hi;
		n  = 0;
		lo = (TEST_TICKS - 1) * CLK_FREQ_KHZ / FRC_FREQ_KHZ + extra;
		hi = (TEST_TICKS + 1) * CLK_FREQ_KHZ / FRC_FREQ_KHZ + extra;
		while (cpu_stall_o === 1'b1 && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		wb(1'b0, ADDR_CONTROL, 32'h0);
		chk("stall time", 32'h1, {31'h0, n < 400 && stall_last >= lo && stall_last <= hi});
		chk("control", ctl, rd);
	endtask : wait_idle
	task automatic t_reset_values();
		wb(1'b0, ADDR_CONTROL, 32'h0);
		chk("control", 32'h0, rd);
		wb(1'b0, ADDR_STATUS, 32'h0);
		chk("status", 32'h0, rd);
		wb(1'b0, ADDR_KEY, 32'h0);
		chk("key", 32'h0, rd);
		wb(1'b1, 8'h40, 32'hffffffff);
		wb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h0, rd);
	endtask : t_reset_values
	task automatic t_refused();
		logic [15:0] ctl;
		for (int m = 0; m < 3; m++) begin
			ctl = (m == 1) ? 16'h8001 : 16'hc001;
			if (m > 0) wb(1'b1, ADDR_KEY, 32'h55);
			if (m == 2) wb(1'b1, ADDR_PAGE, 32'h0);
			if (m > 0) wb(1'b1, ADDR_KEY, 32'haa);
			wb(1'b1, ADDR_CONTROL, {16'h0, ctl});
			wb(1'b0, ADDR_STATUS, 32'h0);
			chk("status", 32'h4, rd & 32'h7);
			chk("stall", 32'h0, {31'h0, cpu_stall_o});
			wb(1'b0, ADDR_CONTROL, 32'h0);
			chk("control", {16'h0, ctl & CTRL_WR_MASK & 16'h7fff}, rd);
			chk("writes", 32'h0, u_flash.write_cnt + u_flash.erase_cnt);
		end
	endtask : t_refused
	task automatic t_erase();
		wb(1'b1, ADDR_PAGE, 32'h01);
		wb(1'b1, ADDR_EA, 32'h1234);
		wb(1'b1, ADDR_TBL_LOW, 32'h0);
		wb(1'b1, ADDR_CONTROL, 32'h4042);
		unlock();
		wb(1'b1, ADDR_CONTROL, 32'hc042);
		wb(1'b0, ADDR_STATUS, 32'h0);
		chk("busy", 32'h1, rd & 32'h1);
		chk("stall", 32'h1, {31'h0, cpu_stall_o});
		wb(1'b1, ADDR_PAGE, 32'h77);
		wait_idle(32'h4042, 2);
		chk("erases", 32'h1, u_flash.erase_cnt);
		chk("erase addr", 32'h011000, {8'h0, u_flash.erase_addr});
		wb(1'b0, ADDR_STATUS, 32'h0);
		chk("status", 32'h00440000, rd & 32'h3fff0007);
		wb(1'b0, ADDR_PAGE, 32'h0);
		chk("page", 32'h01, rd & 32'hff);
	endtask : t_erase
	task automatic t_program();
		for (int p = 0; p < 2; p++) begin
			wb(1'b1, ADDR_PAGE, 32'h02 + p);
			for (int i = 0; i < 64; i++) begin
				wb(1'b1, ADDR_EA, 32'h80 + 2 * i);
				wb(1'b1, ADDR_TBL_LOW, 32'h5a00 + i);
				wb(1'b1, ADDR_TBL_HIGH, 32'hc3 + p);
			end
			wb(1'b1, ADDR_CONTROL, 32'h4001);
			unlock();
			wb(1'b1, ADDR_CONTROL, 32'hc001);
			wait_idle(32'h4001, ROW_WORDS + 1);
			chk("writes", 32'd64 * (p + 1), u_flash.write_cnt);
			chk("row addr", 32'h020080 + 32'h10000 * p, {8'h0, u_flash.first_addr});
			for (int i = 0; i < 64; i++) chk("word", 32'hc35a00 + 32'h10000 * p + i, {8'h0, u_flash.row_mem[i]});
		end
	endtask : t_program
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset_values();
		t_refused();
		t_erase();
		t_program();
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		end_of_test();
	end
endmodule : tb
bind flash_self_program_sequencer flash_seq_checker #(.ROW_FRC_CYCLES(ROW_FRC_CYCLES)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.dat_o(dat_o), .ack_o(ack_o), .cpu_stall_o(cpu_stall_o), .flash_erase_o(flash_erase_o),
	.flash_write_o(flash_write_o), .flash_addr_o(flash_addr_o));
